/* File: common/rx_link_pkg.sv */
// Shared constants and types for the per-port link control register bank
package rx_link_pkg;

  // Port count and register bus widths
  localparam int NUM_PORTS   = 4;
  localparam int PORT_W      = 2;
  localparam int DATA_W      = 8;
  localparam int PARITY_W    = 16;
  localparam int SELFTEST_W  = 8;

  // Register offsets
  localparam logic [7:0] PORT_SELECT_ADDR  = 8'h4c;
  localparam logic [7:0] PARITY_HIGH_ADDR  = 8'h55;
  localparam logic [7:0] PARITY_LOW_ADDR   = 8'h56;
  localparam logic [7:0] SELFTEST_ADDR     = 8'h57;
  localparam logic [7:0] BACK_CHANNEL_ADDR = 8'h58;
  localparam logic [7:0] DATAPATH_ADDR     = 8'h59;

  // Port select fields: read port in 5:4, per-port write enables in 3:0
  localparam int         SEL_READ_LSB      = 4;
  localparam logic [7:0] PORT_SELECT_MASK  = 8'h3f;
  localparam logic [7:0] PORT_SELECT_RESET = 8'h01;

  // Back-channel configuration fields
  localparam int         BCC_PASS_ALL_BIT  = 7;
  localparam int         BCC_PASS_DEC_BIT  = 6;
  localparam int         BCC_AUTO_ACK_BIT  = 5;
  localparam int         BCC_FORCED_ON_BIT = 4;
  localparam int         BCC_CRC_BIT       = 3;
  localparam int         BCC_RATE_LSB      = 0;
  localparam int         RATE_W            = 3;
  localparam logic [7:0] BCC_RESET         = 8'h18;

  // Datapath control fields
  localparam int         DP_KEEP_LOCAL_BIT = 7;
  localparam int         DP_GPIO_LSB       = 0;
  localparam int         GPIO_FIELD_W      = 2;
  localparam logic [7:0] DP_WRITE_MASK     = 8'h83;
  localparam logic [7:0] DP_RESET          = 8'h00;

  // Counter reset values and limits
  localparam logic [PARITY_W-1:0]   PARITY_RESET   = 16'h0000;
  localparam logic [PARITY_W-1:0]   PARITY_MAX     = 16'hffff;
  localparam logic [SELFTEST_W-1:0] SELFTEST_RESET = 8'h00;
  localparam logic [PARITY_W-1:0]   SELFTEST_MAX   = 16'h00ff;

  // Return channel rate codes; other codes are reserved
  typedef enum logic [RATE_W-1:0] {
    RATE_2M5 = 3'b000,
    RATE_10M = 3'b010,
    RATE_50M = 3'b110
  } rate_e;

  // Strap capture sequence after reset release
  typedef enum logic [1:0] {
    CAPTURE_SYNC_A = 2'b00,
    CAPTURE_SYNC_B = 2'b01,
    CAPTURE_LOAD   = 2'b10,
    CAPTURE_RUN    = 2'b11
  } capture_e;

  // Per-port writable registers
  typedef struct packed {
    logic [DATA_W-1:0] bcc;
    logic [DATA_W-1:0] dp;
  } port_regs_s;

endpackage

/* File: common/port_count_if.sv */
// Carrier between the register bank and one port's error counters
`timescale 1ns/1ps
`default_nettype none
interface port_count_if;
  import rx_link_pkg::*;

  logic                  parity_event;
  logic                  lock_event;
  logic                  selftest_event;
  logic                  clear_parity;
  logic [PARITY_W-1:0]   parity_count;
  logic [SELFTEST_W-1:0] selftest_count;

  // Register bank drives events, counters return counts
  modport ctrl (
    output parity_event, lock_event, selftest_event, clear_parity,
    input  parity_count, selftest_count
  );
  modport counter (
    input  parity_event, lock_event, selftest_event, clear_parity,
    output parity_count, selftest_count
  );
endinterface
`default_nettype wire

/* File: hw/port_error_counters.sv */
// Parity and self-test error counters for one receive port
`timescale 1ns/1ps
`default_nettype none
module port_error_counters (
  input  wire logic         clock_in,
  input  wire logic         rst_b_in,
  port_count_if.counter     cnt_if
);
  import rx_link_pkg::*;

  typedef struct packed {
    logic [PARITY_W-1:0]   parity;
    logic [SELFTEST_W-1:0] selftest;
  } count_state_s;

  count_state_s state;
  count_state_s next_state;

  // Saturating increment so a long error burst never wraps to a small value
  function automatic logic [PARITY_W-1:0] sat_inc(input logic [PARITY_W-1:0] value,
                                                  input logic [PARITY_W-1:0] limit);
    sat_inc = (value == limit) ? value : value + 16'h0001;
  endfunction

  // Restart first, then count: an error in the clearing cycle survives
  always_comb begin
    logic [PARITY_W-1:0] selftest_wide;
    selftest_wide = sat_inc({8'h00, state.selftest}, SELFTEST_MAX);  // Wide form of the saturating step
    next_state = state;
    if (cnt_if.clear_parity || cnt_if.lock_event) begin
      next_state.parity = PARITY_RESET;
    end
    if (cnt_if.parity_event) begin
      next_state.parity = sat_inc(next_state.parity, PARITY_MAX);
    end
    if (cnt_if.selftest_event) begin
      next_state.selftest = selftest_wide[SELFTEST_W-1:0];
    end
  end

  // State register
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state.parity   <= PARITY_RESET;
      state.selftest <= SELFTEST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Counts straight from flip-flops
  assign cnt_if.parity_count   = state.parity;
  assign cnt_if.selftest_count = state.selftest;

endmodule
`default_nettype wire

/* File: hw/rx_port_link_ctrl_regs.sv */
// Per-receive-port link control and status register bank
`timescale 1ns/1ps
`default_nettype none
module rx_port_link_ctrl_regs (
  input  wire logic                                              clock_in,
  input  wire logic                                              rst_b_in,
  // Register access from the local controller or from the link
  input  wire logic [7:0]                                        reg_addr_in,
  input  wire logic [rx_link_pkg::DATA_W-1:0]                    reg_wdata_in,
  input  wire logic                                              reg_write_in,
  input  wire logic                                              reg_read_in,
  input  wire logic                                              reg_from_link_in,
  input  wire logic [rx_link_pkg::PORT_W-1:0]                    reg_link_port_in,
  output logic [rx_link_pkg::DATA_W-1:0]                         reg_rdata_out,
  output logic                                                   reg_rvalid_out,
  // Per-port receiver events
  input  wire logic [rx_link_pkg::NUM_PORTS-1:0]                 parity_error_in,
  input  wire logic [rx_link_pkg::NUM_PORTS-1:0]                 lock_valid_in,
  input  wire logic [rx_link_pkg::NUM_PORTS-1:0]                 selftest_error_in,
  // Forward-channel loads of the GPIO field
  input  wire logic [rx_link_pkg::NUM_PORTS-1:0]                 fc_load_in,
  input  wire logic [rx_link_pkg::NUM_PORTS-1:0][1:0]            fc_gpio_in,
  // Rate strap pins
  input  wire logic [rx_link_pkg::RATE_W-1:0]                    rate_strap_in,
  // Per-port control outputs
  output logic [rx_link_pkg::NUM_PORTS-1:0]                      pass_all_out,
  output logic [rx_link_pkg::NUM_PORTS-1:0]                      pass_decoded_out,
  output logic [rx_link_pkg::NUM_PORTS-1:0]                      auto_ack_out,
  output logic [rx_link_pkg::NUM_PORTS-1:0]                      back_channel_on_out,
  output logic [rx_link_pkg::NUM_PORTS-1:0]                      crc_on_out,
  output logic [rx_link_pkg::NUM_PORTS-1:0][rx_link_pkg::RATE_W-1:0] rate_out,
  output logic [rx_link_pkg::NUM_PORTS-1:0]                      rate_reserved_out,
  output logic [rx_link_pkg::NUM_PORTS-1:0][2:0]                 forward_gpio_count_out,
  output logic [rx_link_pkg::NUM_PORTS-1:0]                      keep_local_out
);
  import rx_link_pkg::*;

  typedef struct packed {
    capture_e                         capture;
    logic [RATE_W-1:0]                strap_meta;
    logic [RATE_W-1:0]                strap_sync;
    logic [DATA_W-1:0]                port_select;
    port_regs_s [NUM_PORTS-1:0]       ports;
    logic [NUM_PORTS-1:0]             lock_prev;
    logic [DATA_W-1:0]                rdata;
    logic                             rvalid;
  } bank_state_s;

  bank_state_s state;
  bank_state_s next_state;

  // Per-port carriers to the counters
  logic [NUM_PORTS-1:0][PARITY_W-1:0]   parity_count;
  logic [NUM_PORTS-1:0][SELFTEST_W-1:0] selftest_count;
  logic [NUM_PORTS-1:0]                 clear_parity;
  logic [NUM_PORTS-1:0]                 write_sel;
  logic [PORT_W-1:0]                    read_port;

  // Number of enabled forward GPIOs for a field value
  function automatic logic [2:0] gpio_count(input logic [GPIO_FIELD_W-1:0] field);
    case (field)
      2'b00:   gpio_count = 3'h0;
      2'b01:   gpio_count = 3'h1;
      2'b10:   gpio_count = 3'h2;
      2'b11:   gpio_count = 3'h4;
      default: gpio_count = 3'h0;
    endcase
  endfunction

  // True for the three documented rate codes
  function automatic logic rate_valid(input logic [RATE_W-1:0] code);
    rate_valid = (code == RATE_2M5) || (code == RATE_10M) || (code == RATE_50M);
  endfunction

  // Counters for each port, joined through the carrier interface
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    port_count_if cnt ();

    assign cnt.parity_event   = parity_error_in[p];
    assign cnt.lock_event     = lock_valid_in[p] && !state.lock_prev[p];
    assign cnt.selftest_event = selftest_error_in[p];
    assign cnt.clear_parity   = clear_parity[p];
    assign parity_count[p]    = cnt.parity_count;
    assign selftest_count[p]  = cnt.selftest_count;

    port_error_counters u_counters (
      .clock_in (clock_in),
      .rst_b_in (rst_b_in),
      .cnt_if   (cnt)
    );
  end

  // Port steering: the link reaches only its own port, the host uses 0x4c
  always_comb begin
    if (reg_from_link_in) begin
      write_sel = '0;
      write_sel[reg_link_port_in] = 1'h1;
      read_port = reg_link_port_in;
    end else begin
      write_sel = state.port_select[NUM_PORTS-1:0];
      read_port = state.port_select[SEL_READ_LSB +: PORT_W];
    end
  end

  // Low byte read restarts both count bytes of the addressed port
  always_comb begin
    clear_parity = '0;
    if (reg_read_in && (reg_addr_in == PARITY_LOW_ADDR)) begin
      clear_parity[read_port] = 1'h1;
    end
  end

  // Next-state logic for the whole bank
  always_comb begin
    logic [DATA_W-1:0] new_bcc;
    new_bcc = '0;
    next_state = state;
    next_state.rvalid = 1'h0;
    next_state.lock_prev = lock_valid_in;

    // Strap pins pass two flops before anything looks at them
    next_state.strap_meta = rate_strap_in;
    next_state.strap_sync = state.strap_meta;

    // Rate field is caught once the synchroniser has settled
    case (state.capture)
      CAPTURE_SYNC_A: next_state.capture = CAPTURE_SYNC_B;
      CAPTURE_SYNC_B: next_state.capture = CAPTURE_LOAD;
      CAPTURE_LOAD: begin
        for (int p = 0; p < NUM_PORTS; p++) begin
          next_state.ports[p].bcc[BCC_RATE_LSB +: RATE_W] = state.strap_sync;
        end
        next_state.capture = CAPTURE_RUN;
      end
      CAPTURE_RUN:  next_state.capture = CAPTURE_RUN;
      default:      next_state.capture = CAPTURE_RUN;
    endcase

    // Forward-channel load first, so a host write in the same cycle wins
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (fc_load_in[p] && !state.ports[p].dp[DP_KEEP_LOCAL_BIT]) begin
        next_state.ports[p].dp[DP_GPIO_LSB +: GPIO_FIELD_W] = fc_gpio_in[p];
      end
    end

    // Register writes; counters and reserved bits take nothing
    if (reg_write_in) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (write_sel[p]) begin
          case (reg_addr_in)
            BACK_CHANNEL_ADDR: begin
              new_bcc = reg_wdata_in;
              if (reg_from_link_in) begin
                // Only the local controller may change the forced-on bit
                new_bcc[BCC_FORCED_ON_BIT] =
                  state.ports[p].bcc[BCC_FORCED_ON_BIT];
                // Avoid a control-channel timeout while the link retrains
                if (new_bcc[BCC_RATE_LSB +: RATE_W] !=
                    state.ports[p].bcc[BCC_RATE_LSB +: RATE_W]) begin
                  new_bcc[BCC_AUTO_ACK_BIT] = 1'h1;
                end
              end
              next_state.ports[p].bcc = new_bcc;
            end
            DATAPATH_ADDR: begin
              next_state.ports[p].dp = reg_wdata_in & DP_WRITE_MASK;
            end
            default: begin
              next_state.ports[p] = next_state.ports[p];
            end
          endcase
        end
      end
      if (!reg_from_link_in && (reg_addr_in == PORT_SELECT_ADDR)) begin
        next_state.port_select = reg_wdata_in & PORT_SELECT_MASK;
      end
    end

    // Read data registered one cycle after the strobe
    if (reg_read_in) begin
      next_state.rvalid = 1'h1;
      case (reg_addr_in)
        PORT_SELECT_ADDR:  next_state.rdata = state.port_select;
        PARITY_HIGH_ADDR:  next_state.rdata = parity_count[read_port][15:8];
        PARITY_LOW_ADDR:   next_state.rdata = parity_count[read_port][7:0];
        SELFTEST_ADDR:     next_state.rdata = selftest_count[read_port];
        BACK_CHANNEL_ADDR: next_state.rdata = state.ports[read_port].bcc;
        DATAPATH_ADDR:     next_state.rdata = state.ports[read_port].dp;
        default:           next_state.rdata = 8'h00;
      endcase
    end
  end

  // State register; rate bits hold zero until the strap is caught
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state.capture     <= CAPTURE_SYNC_A;
      state.strap_meta  <= '0;
      state.strap_sync  <= '0;
      state.port_select <= PORT_SELECT_RESET;
      for (int p = 0; p < NUM_PORTS; p++) begin
        state.ports[p].bcc <= BCC_RESET;
        state.ports[p].dp  <= DP_RESET;
      end
      state.lock_prev   <= '0;
      state.rdata       <= 8'h00;
      state.rvalid      <= 1'h0;
    end else begin
      state <= next_state;
    end
  end

  // Control outputs decoded from the stored register bits
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      pass_all_out[p]     = state.ports[p].bcc[BCC_PASS_ALL_BIT];
      pass_decoded_out[p] = state.ports[p].bcc[BCC_PASS_DEC_BIT];
      auto_ack_out[p]     = state.ports[p].bcc[BCC_AUTO_ACK_BIT];
      back_channel_on_out[p] = state.ports[p].bcc[BCC_FORCED_ON_BIT]
                               || state.ports[p].bcc[BCC_PASS_ALL_BIT]
                               || state.ports[p].bcc[BCC_PASS_DEC_BIT];
      crc_on_out[p]       = state.ports[p].bcc[BCC_CRC_BIT];
      rate_out[p]         = state.ports[p].bcc[BCC_RATE_LSB +: RATE_W];
      rate_reserved_out[p] = !rate_valid(state.ports[p].bcc[BCC_RATE_LSB +: RATE_W]);
      forward_gpio_count_out[p] =
        gpio_count(state.ports[p].dp[DP_GPIO_LSB +: GPIO_FIELD_W]);
      keep_local_out[p]   = state.ports[p].dp[DP_KEEP_LOCAL_BIT];
    end
  end

  // Read answer straight from flops
  assign reg_rdata_out  = state.rdata;
  assign reg_rvalid_out = state.rvalid;

endmodule
`default_nettype wire

/* File: tb/rx_port_link_ctrl_regs_monitor.sv */
// Concurrent checks on the port pins of the link control register bank
`timescale 1ns/1ps
`default_nettype none
module rx_port_link_ctrl_regs_monitor (
  input wire logic                                                   clock_in,
  input wire logic                                                   rst_b_in,
  input wire logic [7:0]                                             reg_addr_in,
  input wire logic [rx_link_pkg::DATA_W-1:0]                         reg_wdata_in,
  input wire logic                                                   reg_write_in,
  input wire logic                                                   reg_read_in,
  input wire logic                                                   reg_from_link_in,
  input wire logic [rx_link_pkg::PORT_W-1:0]                         reg_link_port_in,
  input wire logic [rx_link_pkg::DATA_W-1:0]                         reg_rdata_out,
  input wire logic                                                   reg_rvalid_out,
  input wire logic [rx_link_pkg::NUM_PORTS-1:0]                      parity_error_in,
  input wire logic [rx_link_pkg::NUM_PORTS-1:0]                      fc_load_in,
  input wire logic [rx_link_pkg::NUM_PORTS-1:0][1:0]                 fc_gpio_in,
  input wire logic [rx_link_pkg::NUM_PORTS-1:0]                      pass_all_out,
  input wire logic [rx_link_pkg::NUM_PORTS-1:0]                      pass_decoded_out,
  input wire logic [rx_link_pkg::NUM_PORTS-1:0]                      auto_ack_out,
  input wire logic [rx_link_pkg::NUM_PORTS-1:0]                      back_channel_on_out,
  input wire logic [rx_link_pkg::NUM_PORTS-1:0][rx_link_pkg::RATE_W-1:0] rate_out,
  input wire logic [rx_link_pkg::NUM_PORTS-1:0]                      rate_reserved_out,
  input wire logic [rx_link_pkg::NUM_PORTS-1:0][2:0]                 forward_gpio_count_out,
  input wire logic [rx_link_pkg::NUM_PORTS-1:0]                      keep_local_out
);
  import rx_link_pkg::*;
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);

  // Low byte read with no parity error landing in the same cycle
  sequence low_read_quiet;
    reg_read_in && !reg_write_in && reg_addr_in == PARITY_LOW_ADDR && parity_error_in == '0;
  endsequence
  // Idle cycle between reads, no parity error counted
  sequence idle_gap;
    !reg_read_in && !reg_write_in && parity_error_in == '0;
  endsequence
  // Later read aimed at the same port
  sequence same_port_read(logic [7:0] a);
    reg_read_in && reg_addr_in == a && $stable({reg_from_link_in, reg_link_port_in});
  endsequence

  AST_LOW_READ_CLEARS: assert property (
    low_read_quiet ##1 idle_gap ##1 same_port_read(PARITY_LOW_ADDR) |=> reg_rdata_out == 8'h00)
    else $error("low parity byte not cleared by read");
  AST_HIGH_READ_CLEARS: assert property (
    low_read_quiet ##1 idle_gap ##1 same_port_read(PARITY_HIGH_ADDR) |=> reg_rdata_out == 8'h00)
    else $error("high parity byte not cleared by low read");
  AST_UNMAPPED_READS_ZERO: assert property (
    reg_read_in && reg_addr_in == 8'h5a |=> reg_rvalid_out && reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_BC_ON_FOLLOWS_PASS: assert property (
    (back_channel_on_out & (pass_all_out | pass_decoded_out)) == (pass_all_out | pass_decoded_out))
    else $error("back channel off while pass-through set");
  AST_RATE_CHANGE_AUTO_ACK: assert property (
    reg_write_in && reg_from_link_in && reg_addr_in == BACK_CHANNEL_ADDR
      && reg_wdata_in[2:0] != rate_out[reg_link_port_in] |=> auto_ack_out[$past(reg_link_port_in)])
    else $error("rate change over link left auto-ack off");

  // Per-port decode and forward load checks
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    AST_RATE_FLAG: assert property (
      rate_reserved_out[p] == !(rate_out[p] inside {RATE_2M5, RATE_10M, RATE_50M}))
      else $error("rate reserved flag wrong");
    AST_GPIO_DECODE: assert property (
      forward_gpio_count_out[p] inside {3'h0, 3'h1, 3'h2, 3'h4})
      else $error("gpio count not a legal decode");
    AST_KEEP_LOCAL_HOLDS: assert property (
      keep_local_out[p] && fc_load_in[p] && !reg_write_in |=> $stable(forward_gpio_count_out[p]))
      else $error("forward load overwrote kept value");
    AST_FC_LOAD_TAKEN: assert property (
      !keep_local_out[p] && fc_load_in[p] && !reg_write_in |=> forward_gpio_count_out[p] ==
        ($past(fc_gpio_in[p]) == 2'b11 ? 3'h4 : {1'b0, $past(fc_gpio_in[p])}))
      else $error("forward load not taken");
  end
endmodule

bind rx_port_link_ctrl_regs rx_port_link_ctrl_regs_monitor i_rx_port_link_ctrl_regs_monitor (
  .clock_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
  .reg_from_link_in, .reg_link_port_in, .reg_rdata_out, .reg_rvalid_out, .parity_error_in,
  .fc_load_in, .fc_gpio_in, .pass_all_out, .pass_decoded_out, .auto_ack_out,
  .back_channel_on_out, .rate_out, .rate_reserved_out, .forward_gpio_count_out, .keep_local_out
);
`default_nettype wire

/* File: tb/rx_serializer_model.sv */
// Remote serializer and link receiver model: error events, lock, GPIO loads
`timescale 1ns/1ps
`default_nettype none
module rx_serializer_model (
  input  wire logic       clock_in,
  output logic [3:0]      parity_error_out,
  output logic [3:0]      lock_valid_out,
  output logic [3:0]      selftest_error_out,
  output logic [3:0]      fc_load_out,
  output logic [3:0][1:0] fc_gpio_out
);
  initial begin
    {parity_error_out, selftest_error_out, fc_load_out} = '0;
    lock_valid_out = 4'hf;
    fc_gpio_out = '0;
  end
  // Error pulses on one port, one cycle each with a gap between
  task automatic burst(input bit kind, input int port, input int n);
    repeat (n) begin
      @(posedge clock_in); #1;
      if (kind) selftest_error_out[port] = 1'b1;
      else parity_error_out[port] = 1'b1;
      @(posedge clock_in); #1;
      {parity_error_out, selftest_error_out} = '0;
    end
  endtask
  // Lock lost for a cycle then regained
  task automatic relock(input int port);
    @(posedge clock_in); #1;
    lock_valid_out[port] = 1'b0;
    @(posedge clock_in); #1;
    lock_valid_out[port] = 1'b1;
  endtask
  // GPIO count pushed over the forward channel; field shows garbage once released
  task automatic load(input int port, input logic [1:0] g);
    @(posedge clock_in); #1;
    fc_gpio_out[port] = g;
    fc_load_out[port] = 1'b1;
    @(posedge clock_in); #1;
    fc_load_out[port] = 1'b0;
    fc_gpio_out[port] = ~g;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_rx_port_link_ctrl_regs.sv */
// Register-level testbench for the link control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_rx_port_link_ctrl_regs;
  import rx_link_pkg::*;
  logic            clock_in = 0, rst_b_in = 0, reg_write_in = 0, reg_read_in = 0;
  logic            reg_from_link_in = 0, reg_rvalid_out;
  logic [7:0]      reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, v;
  logic [1:0]      reg_link_port_in = 0;
  logic [2:0]      rate_strap_in = 3'h6;
  logic [3:0]      parity_error_in, lock_valid_in, selftest_error_in, fc_load_in;
  logic [3:0]      pass_all_out, pass_decoded_out, auto_ack_out, back_channel_on_out;
  logic [3:0]      crc_on_out, rate_reserved_out, keep_local_out;
  logic [3:0][1:0] fc_gpio_in;
  logic [3:0][2:0] rate_out, forward_gpio_count_out;
  int              mismatches = 0, samples_checked = 0;
  logic [7:0]      bcc_table [9] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h08, 8'h12, 8'h16, 8'h05, 8'h03};

  rx_port_link_ctrl_regs i_rx_port_link_ctrl_regs (
    .clock_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
    .reg_from_link_in, .reg_link_port_in, .reg_rdata_out, .reg_rvalid_out, .parity_error_in,
    .lock_valid_in, .selftest_error_in, .fc_load_in, .fc_gpio_in, .rate_strap_in,
    .pass_all_out, .pass_decoded_out, .auto_ack_out, .back_channel_on_out, .crc_on_out,
    .rate_out, .rate_reserved_out, .forward_gpio_count_out, .keep_local_out
  );
  rx_serializer_model i_rx_serializer_model (
    .clock_in, .parity_error_out(parity_error_in), .lock_valid_out(lock_valid_in),
    .selftest_error_out(selftest_error_in), .fc_load_out(fc_load_in), .fc_gpio_out(fc_gpio_in)
  );

  // 200 MHz clock
  initial begin
    forever #2.5 clock_in = ~clock_in;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One write strobe; an edge always passes before the next request
  task automatic wr(input logic [7:0] a, d, input logic lk = 0, input logic [1:0] p = 0);
    @(posedge clock_in); #1;
    {reg_addr_in, reg_wdata_in, reg_from_link_in, reg_link_port_in} = {a, d, lk, p};
    reg_write_in = 1'b1;
    @(posedge clock_in); #1;
    reg_write_in = 1'b0;
  endtask
  // One read strobe; valid and data are looked at in the cycle they stand
  task automatic rd(input logic [7:0] a, exp, input logic lk = 0, input logic [1:0] p = 0);
    @(posedge clock_in); #1;
    {reg_addr_in, reg_from_link_in, reg_link_port_in} = {a, lk, p};
    reg_read_in = 1'b1;
    @(posedge clock_in); #1;
    reg_read_in = 1'b0;
    chk({7'h00, reg_rvalid_out, reg_rdata_out}, {8'h01, exp});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog, far beyond the several hundred cycles the tests need
  initial begin
    #50000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge clock_in);
    #1 rst_b_in = 1'b1;
    repeat (8) @(posedge clock_in);
    rd(8'h58, 8'h1e);
    chk({crc_on_out, back_channel_on_out, rate_out}, {8'hff, 12'hdb6});
    for (int i = 0; i < 3; i++) rd(8'h55 + 8'(i), 8'h00);
    rd(8'h59, 8'h00);
    $display("reset values done");
    // Parity count: read port 1, parity checker kept quiet during reads
    wr(8'h4c, 8'h11);
    i_rx_serializer_model.burst(0, 1, 300);
    rd(8'h55, 8'h01);
    rd(8'h56, 8'h2c);
    rd(8'h55, 8'h00);
    rd(8'h56, 8'h00);
    rd(8'h56, 8'h00);
    i_rx_serializer_model.burst(0, 1, 5);
    i_rx_serializer_model.relock(1);
    rd(8'h56, 8'h00);
    i_rx_serializer_model.burst(0, 1, 3);
    rd(8'h56, 8'h03, 1, 1);
    $display("parity count done");
    // Self-test count, write attempt ignored
    i_rx_serializer_model.burst(1, 2, 3);
    wr(8'h57, 8'hff, 1, 2);
    rd(8'h57, 8'h03, 1, 2);
    $display("self-test count done");
    // Back-channel fields on all ports
    wr(8'h4c, 8'h0f);
    foreach (bcc_table[i]) begin
      v = bcc_table[i];
      wr(8'h58, v);
      chk({pass_all_out, pass_decoded_out, auto_ack_out, crc_on_out},
          {{4{v[7]}}, {4{v[6]}}, {4{v[5]}}, {4{v[3]}}});
      chk({back_channel_on_out, rate_reserved_out},
          {{4{v[7] | v[6] | v[4]}}, {4{!(v[2:0] inside {3'h0, 3'h2, 3'h6})}}});
      chk(rate_out, {4{v[2:0]}});
      rd(8'h58, v);
    end
    $display("back channel fields done");
    // Link writes: forced-on bit refused, rate change sets auto-ack
    wr(8'h58, 8'h13, 1, 3);
    rd(8'h58, 8'h03, 1, 3);
    chk({back_channel_on_out, auto_ack_out}, 8'h00);
    wr(8'h58, 8'h06, 1, 3);
    rd(8'h58, 8'h26, 1, 3);
    chk(auto_ack_out, 4'h8);
    wr(8'h4c, 8'h30, 1, 0);
    rd(8'h4c, 8'h0f);
    $display("link writes done");
    // Datapath: kept local value, then forward loads of each code
    wr(8'h59, 8'hff);
    rd(8'h59, 8'h83);
    chk({keep_local_out, forward_gpio_count_out}, 16'hf924);
    i_rx_serializer_model.load(0, 2'b01);
    chk(forward_gpio_count_out[0], 3'h4);
    wr(8'h59, 8'h02);
    for (int g = 3; g >= 0; g--) begin
      i_rx_serializer_model.load(0, 2'(g));
      chk(forward_gpio_count_out[0], (g == 3) ? 3'h4 : 3'(g));
    end
    $display("datapath done");
    // Port steering and reserved places
    wr(8'h4c, 8'h04);
    wr(8'h58, 8'h80);
    chk(pass_all_out, 4'h4);
    rd(8'h5a, 8'h00);
    wr(8'h4c, 8'hff);
    rd(8'h4c, 8'h3f);
    $display("steering done");
    complete_run();
  end
endmodule
`default_nettype wire
